// ===== common/msdec_defs.svh
// Constants shared by the modulator end and the decimator end.
// Assumes inclusion by bare name from the common folder.
`ifndef MSDEC_DEFS_SVH
`define MSDEC_DEFS_SVH
`define MSDEC_WORD_WIDTH     24
`define MSDEC_RATIO_DEFAULT  256
`define MSDEC_RATIO_MIN      16
`define MSDEC_RATIO_MAX      256
`define MSDEC_RESULT_BITS    16
`define MSDEC_LEVEL_WIDTH    16
`define MSDEC_LEVEL_ZERO     16'h0000
`define MSDEC_LEVEL_LIN_POS  16'h63ff
`define MSDEC_LEVEL_LIN_NEG  16'h9c01
`define MSDEC_LEVEL_CLIP_POS 16'h7fff
`define MSDEC_LEVEL_CLIP_NEG 16'h8001
`define MSDEC_DENS_LIN_POS   16'he3ff
`define MSDEC_DENS_LIN_NEG   16'h1c01
`define MSDEC_DENS_HALF      16'h8000
`define MSDEC_CLK_DIV_HALF   8'h04
`endif

// ===== common/msdec_pkg.sv
// Types shared by both ends of the modulator stream link.
// Assumes msdec_defs.svh is on the include path.
`include "msdec_defs.svh"
package msdec_pkg;
  typedef logic [`MSDEC_WORD_WIDTH-1:0]  msdec_word_type;
  typedef logic [`MSDEC_LEVEL_WIDTH-1:0] msdec_level_type;
endpackage : msdec_pkg

// ===== common/msdec_link_if.sv
// Link between modulator and decimator: clock from filter, bit back.
// Assumes both ends run on the same sys_clk.
`timescale 1ns/100ps
`default_nettype none
interface msdec_link_if;
  logic modulator_clock_in;
  logic stream_bit_in;
  modport modulator (input modulator_clock_in, output stream_bit_in);
  modport filter    (output modulator_clock_in, input stream_bit_in);
endinterface : msdec_link_if
`default_nettype wire

// ===== src/msdec_modulator.sv
// Modulator end: turns a signed input level into a ones-density stream.
// Assumes link clock is sampled from outside; level is a same-clock input.
`timescale 1ns/100ps
`default_nettype none
`include "msdec_defs.svh"
module msdec_modulator (
  input  wire logic                     sys_clk,
  input  wire logic                     rst,
  input  wire msdec_pkg::msdec_level_type input_level,
  msdec_link_if.modulator               link,
  output logic                          clipped
);
  logic [2:0]                  clk_sync;
  logic                        comparator;
  logic [`MSDEC_LEVEL_WIDTH:0] accum;
  logic [`MSDEC_LEVEL_WIDTH-1:0] density;
  logic                        bit_out;
  logic signed [`MSDEC_LEVEL_WIDTH-1:0] lvl;
  logic                        fall_edge;
  logic                        rise_edge;
  logic [`MSDEC_LEVEL_WIDTH:0] next_accum;

  assign lvl = signed'(input_level);
  // An edge is acted on when the second and third stages differ
  assign fall_edge = clk_sync[2] & ~clk_sync[1];
  assign rise_edge = ~clk_sync[2] & clk_sync[1];

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      clk_sync <= 3'h0;
    end else begin
      clk_sync <= {clk_sync[1:0], link.modulator_clock_in};
    end
  end

  // Density map: linear to the limits, flattened beyond, clipped past
  always_comb begin
    if (lvl <= signed'(`MSDEC_LEVEL_CLIP_NEG)) begin
      density = 16'h0000;
    end else if (lvl >= signed'(`MSDEC_LEVEL_CLIP_POS)) begin
      density = 16'hffff;
    end else if (lvl > signed'(`MSDEC_LEVEL_LIN_POS)) begin
      density = `MSDEC_DENS_LIN_POS + 16'((lvl - signed'(`MSDEC_LEVEL_LIN_POS)) >>> 3);
    end else if (lvl < signed'(`MSDEC_LEVEL_LIN_NEG)) begin
      density = `MSDEC_DENS_LIN_NEG - 16'((signed'(`MSDEC_LEVEL_LIN_NEG) - lvl) >>> 3);
    end else begin
      // 0 -> half, linear limit -> 89.06 %, -limit -> 10.94 %
      density = `MSDEC_DENS_HALF + 16'(lvl);
    end
  end

  // First-order error feedback stands in for the loop; density is exact
  assign next_accum = {1'b0, accum[`MSDEC_LEVEL_WIDTH-1:0]} + {1'b0, density};

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      accum      <= 17'h00000;
      comparator <= 1'b0;
    end else if (rise_edge) begin
      accum      <= next_accum;
      comparator <= next_accum[`MSDEC_LEVEL_WIDTH] | (density == 16'hffff);
    end
  end

  // Feedback bit follows the comparator four clocks later, on falling edge
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bit_out <= 1'b0;
    end else if (fall_edge) begin
      bit_out <= comparator;
    end
  end
  assign link.stream_bit_in = bit_out;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      clipped <= 1'b0;
    end else begin
      clipped <= (density == 16'h0000) | (density == 16'hffff);
    end
  end
endmodule : msdec_modulator
`default_nettype wire

// ===== src/msdec_filter.sv
// Decimator end: drives the modulator clock, runs the sinc3 filter.
// Assumes the stream bit arrives from the far side, unsynchronised.
`timescale 1ns/100ps
`default_nettype none
`include "msdec_defs.svh"
module msdec_filter #(
  parameter int unsigned RATIO = `MSDEC_RATIO_DEFAULT
) (
  input  wire logic               sys_clk,
  input  wire logic               rst,
  input  wire logic               async_clear_n,
  msdec_link_if.filter            link,
  output msdec_pkg::msdec_word_type filter_result,
  output logic [`MSDEC_RESULT_BITS-1:0] result_word,
  output logic                    result_valid,
  output logic                    decimation_strobe
);
  localparam int unsigned DIV_HALF = `MSDEC_CLK_DIV_HALF;
  msdec_pkg::msdec_word_type ones_counter;
  msdec_pkg::msdec_word_type second_integrator;
  msdec_pkg::msdec_word_type third_integrator;
  msdec_pkg::msdec_word_type capture_reg;
  msdec_pkg::msdec_word_type previous_capture_reg;
  msdec_pkg::msdec_word_type first_difference_delay;
  msdec_pkg::msdec_word_type second_difference_delay;
  msdec_pkg::msdec_word_type first_difference;
  msdec_pkg::msdec_word_type second_difference;
  msdec_pkg::msdec_word_type next_result;
  logic [7:0]  div_count;
  logic        mod_clk;
  logic [8:0]  ratio_count;
  logic [2:0]  bit_sync;
  logic [2:0]  clr_sync;
  logic        clear;
  logic        sample_edge;

  // Clear is asynchronous in assertion; it reaches every register below except the divider and bit_sync
  always_ff @(posedge sys_clk or negedge async_clear_n) begin
    if (!async_clear_n) begin
      clr_sync <= 3'h0;
    end else begin
      clr_sync <= {clr_sync[1:0], 1'b1};
    end
  end
  // Release counts only once the last two stages are both high
  assign clear = rst | ~(clr_sync[2] & clr_sync[1]);

  // Modulator clock made here by dividing sys_clk
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      div_count <= 8'h00;
    end else if (div_count == 8'(DIV_HALF - 1)) begin
      div_count <= 8'h00;
    end else begin
      div_count <= div_count + 8'h01;
    end
  end

  // Divider ignores the clear so the far end never sees the clock stop
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mod_clk <= 1'b0;
    end else if (div_count == 8'(DIV_HALF - 1)) begin
      mod_clk <= ~mod_clk;
    end
  end
  assign link.modulator_clock_in = mod_clk;
  // Rising edge about to happen: bit counted was set nine clocks earlier, after the falling edge one period back
  assign sample_edge = ~mod_clk & (div_count == 8'(DIV_HALF - 1));

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bit_sync <= 3'h0;
    end else begin
      bit_sync <= {bit_sync[1:0], link.stream_bit_in};
    end
  end

  // Integrators, one step per modulator rising edge
  always_ff @(posedge sys_clk) begin
    if (clear) begin
      ones_counter <= 24'h000000;
    end else if (sample_edge & bit_sync[2] & bit_sync[1]) begin
      ones_counter <= ones_counter + 24'h000001;
    end
  end

  // Wraps at 24 bits; the comb section undoes the wrap
  always_ff @(posedge sys_clk) begin
    if (clear) begin
      second_integrator <= 24'h000000;
    end else if (sample_edge) begin
      second_integrator <= second_integrator + ones_counter;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (clear) begin
      third_integrator <= 24'h000000;
    end else if (sample_edge) begin
      third_integrator <= third_integrator + second_integrator;
    end
  end

  // Strobe every RATIO modulator periods
  always_ff @(posedge sys_clk) begin
    if (clear) begin
      ratio_count <= 9'h000;
    end else if (sample_edge) begin
      if (ratio_count == 9'(RATIO - 1)) begin
        ratio_count <= 9'h000;
      end else begin
        ratio_count <= ratio_count + 9'h001;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (clear) begin
      decimation_strobe <= 1'b0;
    end else begin
      decimation_strobe <= sample_edge & (ratio_count == 9'(RATIO - 1));
    end
  end

  always_ff @(posedge sys_clk) begin
    if (clear) begin
      capture_reg             <= 24'h000000;
      previous_capture_reg    <= 24'h000000;
      first_difference_delay  <= 24'h000000;
      second_difference_delay <= 24'h000000;
    end else if (decimation_strobe) begin
      capture_reg             <= third_integrator;
      previous_capture_reg    <= capture_reg;
      first_difference_delay  <= first_difference;
      second_difference_delay <= second_difference;
    end
  end

  // Comb section; response notches and -3 dB follow from the sinc3 form
  assign first_difference  = capture_reg - previous_capture_reg;
  assign second_difference = first_difference - first_difference_delay;
  assign next_result       = second_difference - second_difference_delay;

  // Registered result, updated the cycle after each capture
  logic strobe_d;
  always_ff @(posedge sys_clk) begin
    if (clear) begin
      strobe_d <= 1'b0;
    end else begin
      strobe_d <= decimation_strobe;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (clear) begin
      result_valid <= 1'b0;
    end else begin
      result_valid <= strobe_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (clear) begin
      filter_result <= 24'h000000;
    end else if (strobe_d) begin
      filter_result <= next_result;
    end
  end

  // Top 16 of 24 result bits; at ratio 256 a full-scale 2^24 wraps to 0
  always_ff @(posedge sys_clk) begin
    if (clear) begin
      result_word <= 16'h0000;
    end else if (strobe_d) begin
      result_word <= next_result[`MSDEC_WORD_WIDTH-1 -: `MSDEC_RESULT_BITS];
    end
  end
endmodule : msdec_filter
`default_nettype wire

// ===== tb/msdec_checker_sva.sv
// Checker on the link and the decimator outputs.
// Assumes one sys_clk for both ends; RATIO matches the filter.
`timescale 1ns/100ps
`default_nettype none
`include "msdec_defs.svh"
module msdec_checker #(
  parameter int unsigned RATIO = 16
) (
  input wire logic                      sys_clk,
  input wire logic                      rst,
  input wire logic                      async_clear_n,
  input wire logic                      modulator_clock_in,
  input wire logic                      stream_bit_in,
  input wire logic                      decimation_strobe,
  input wire logic                      result_valid,
  input wire msdec_pkg::msdec_word_type filter_result,
  input wire logic [`MSDEC_RESULT_BITS-1:0] result_word
);
  localparam int GAP = RATIO * 8;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  chk_bit_quiet_high: assert property ($rose(modulator_clock_in) |=> $stable(stream_bit_in)[*3])
    else $error("stream bit moved in high phase");
  chk_clock_period: assert property ($rose(modulator_clock_in) |->
    modulator_clock_in[*4] ##1 !modulator_clock_in[*4] ##1 modulator_clock_in)
    else $error("link clock period wrong");
  chk_one_bit_period: assert property ($changed(stream_bit_in) |=> $stable(stream_bit_in)[*7])
    else $error("two bits in one period");
  chk_strobe_single: assert property (decimation_strobe |=> !decimation_strobe)
    else $error("strobe longer than a cycle");
  // Clear restarts the word count, so it cancels pending spacing checks
  chk_strobe_spacing: assert property (disable iff (rst || !async_clear_n)
    decimation_strobe |-> ##GAP decimation_strobe) else $error("strobe spacing wrong");
  chk_valid_lag: assert property (disable iff (rst || !async_clear_n)
    decimation_strobe |-> ##2 result_valid) else $error("valid missing after strobe");
  chk_valid_cause: assert property (disable iff (rst || !async_clear_n)
    result_valid |-> $past(decimation_strobe, 2)) else $error("valid without strobe");
  chk_word_slice: assert property (result_valid |-> result_word == filter_result[23:8])
    else $error("result word not top bits");
endmodule : msdec_checker
`default_nettype wire

// ===== tb/tb_modulator_bitstream_sinc3_decimator.sv
// Bench: modulator end and decimator end joined by the link.
// Assumes RATIO 16, so a steady sinc3 result is 4096 times the density.
`timescale 1ns/100ps
`default_nettype none
`include "msdec_defs.svh"
module tb_modulator_bitstream_sinc3_decimator;
  localparam int unsigned RATIO = 16;
  logic                          sys_clk = 1'b0;
  logic                          rst = 1'b1;
  logic                          async_clear_n = 1'b1;
  logic                          result_valid;
  logic                          decimation_strobe;
  logic                          clipped;
  logic [`MSDEC_RESULT_BITS-1:0] result_word;
  msdec_pkg::msdec_word_type     filter_result;
  msdec_pkg::msdec_level_type    input_level = `MSDEC_LEVEL_ZERO;
  int                            errors = 0;
  int                            check_count = 0;
  int                            cycles = 0;
  msdec_link_if link ();
  msdec_modulator u_msdec_modulator (.sys_clk(sys_clk), .rst(rst), .input_level(input_level),
    .link(link.modulator), .clipped(clipped));
  msdec_filter #(.RATIO(RATIO)) u_msdec_filter (.sys_clk(sys_clk), .rst(rst), .async_clear_n(async_clear_n),
    .link(link.filter), .filter_result(filter_result), .result_word(result_word),
    .result_valid(result_valid), .decimation_strobe(decimation_strobe));
  msdec_checker #(.RATIO(RATIO)) u_msdec_checker (.sys_clk(sys_clk), .rst(rst), .async_clear_n(async_clear_n),
    .modulator_clock_in(link.modulator_clock_in), .stream_bit_in(link.stream_bit_in),
    .decimation_strobe(decimation_strobe), .result_valid(result_valid), .filter_result(filter_result),
    .result_word(result_word));
  always #10 sys_clk = ~sys_clk;
  task automatic give_verdict();
    if (errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      give_verdict();
    end
  end
  task automatic step();
    @(posedge sys_clk);
    #1;
  endtask : step
  task automatic check_range(input string what, input logic [23:0] seen, input int lo, input int hi);
    check_count++;
    if ((seen >= lo && seen <= hi) !== 1'b1) begin
      errors++;
      $display("CHECK FAILED %s expected %0d..%0d seen %0d", what, lo, hi, seen);
    end
  endtask : check_range
  task automatic wait_strobe();
    step();
    for (int n = 0; n < 200 && decimation_strobe !== 1'b1; n++) step();
    check_range("strobe", 24'(decimation_strobe), 1, 1);
  endtask : wait_strobe
  task automatic strobe_case();
    logic [23:0] gap;
    logic [23:0] rises;
    logic        prev;
    wait_strobe();
    gap = 0;
    rises = 0;
    prev = link.modulator_clock_in;
    do begin
      step();
      gap++;
      rises += 24'(link.modulator_clock_in && !prev);
      prev = link.modulator_clock_in;
    end while (decimation_strobe !== 1'b1 && gap < 400);
    check_range("strobe gap", gap, 8 * RATIO, 8 * RATIO);
    check_range("link clocks per word", rises, RATIO, RATIO);
  endtask : strobe_case
  // Sinc3 needs three words to settle; five flush the old level too
  task automatic level_case(input msdec_pkg::msdec_level_type lvl, input int res_lo, input int res_hi,
                            input int ones_lo, input int ones_hi, input logic exp_clip);
    logic [23:0] ones;
    logic        prev;
    input_level = lvl;
    repeat (5) wait_strobe();
    step();
    step();
    check_range("result valid", 24'(result_valid), 1, 1);
    check_range("filter result", filter_result, res_lo, res_hi);
    check_range("clipped", 24'(clipped), 24'(exp_clip), 24'(exp_clip));
    ones = 0;
    prev = link.modulator_clock_in;
    repeat (2048) begin
      step();
      if (link.modulator_clock_in && !prev) begin
        ones += 24'(link.stream_bit_in);
      end
      prev = link.modulator_clock_in;
    end
    check_range("ones in 256 bits", ones, ones_lo, ones_hi);
  endtask : level_case
  initial begin
    repeat (2) step();
    rst = 1'b0;
    check_range("result after reset", filter_result, 0, 0);
    strobe_case();
    level_case(`MSDEC_LEVEL_ZERO, 2000, 2096, 126, 130, 1'b0);
    level_case(`MSDEC_LEVEL_LIN_POS, 3600, 3696, 225, 231, 1'b0);
    async_clear_n = 1'b0;
    repeat (4) step();
    check_range("cleared result", filter_result, 0, 0);
    async_clear_n = 1'b1;
    level_case(`MSDEC_LEVEL_LIN_NEG, 400, 496, 25, 31, 1'b0);
    level_case(16'h6d00, 3560, 4090, 221, 255, 1'b0);
    level_case(`MSDEC_LEVEL_CLIP_POS, 4096, 4096, 256, 256, 1'b1);
    level_case(`MSDEC_LEVEL_CLIP_NEG, 0, 0, 0, 0, 1'b1);
    give_verdict();
  end
endmodule : tb_modulator_bitstream_sinc3_decimator
`default_nettype wire
